//--- src/prescaler_pkg.sv
package prescaler_pkg;

   // Avalon byte addresses of the configuration words (index times four)
   localparam int unsigned factor_low_idx = 32'h46;
   localparam int unsigned factor_high_idx = 32'h47;
   localparam int unsigned divider_status_idx = 32'h49;
   localparam logic [9:0] factor_low_addr = 10'(factor_low_idx * 4);
   localparam logic [9:0] factor_high_addr = 10'(factor_high_idx * 4);
   localparam logic [9:0] divider_status_addr = 10'(divider_status_idx * 4);

   localparam int unsigned factor_w = 14;
   localparam int unsigned high_field_w = 6;
   localparam logic [7:0] factor_low_rst = 8'hff;
   localparam logic [7:0] factor_high_rst = 8'h3f;
   localparam logic [13:0] factor_max = 14'h30d3;

   // Status word fields
   localparam int unsigned stat_run_bit = 0;
   localparam int unsigned stat_over_bit = 1;

   // Highest reference rate, in MHz
   localparam int unsigned ref_max_mhz = 100;

   typedef struct packed {
      logic [9:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } av_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } av_rsp_s;

endpackage : prescaler_pkg

//--- src/ref_divider.sv
`timescale 1ns/1ps
module ref_divider
   import prescaler_pkg::*;
#(
   parameter int unsigned width = factor_w
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Reference in and divided enable out
   input wire logic ref_tick,
   input wire logic [width-1:0] factor,
   output logic div_tick
);

   logic [width-1:0] cnt_r;
   logic [width-1:0] cnt_nxt;
   logic wrap;

   assign wrap = (cnt_r >= factor);
   assign cnt_nxt = wrap ? '0 : cnt_r + width'(1);

   // One output per factor+1 reference ticks; zero passes through
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         div_tick <= 1'b0;
      end else begin
         div_tick <= ref_tick & wrap;
         if (ref_tick) begin
            cnt_r <= cnt_nxt;
         end
      end
   end

endmodule : ref_divider

//--- src/input_ref_prescaler.sv
//Function
//- Hold a 14-bit factor split over low byte and high byte bits 5..0
//- The combined factor sets the integer divide of enabled references
//- Reference inputs up to 100 MHz are accepted
//- Reset values: low byte ff, high byte 3f
`timescale 1ns/1ps
module input_ref_prescaler
   import prescaler_pkg::*;
#(
   parameter int unsigned fw = factor_w
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Reference path
   input wire logic ref_clk_in,
   input wire logic divide_en,
   output logic ref_out
);

   if (fw != factor_w) begin : g_chk
      $error("prescaler factor width must be 14");
   end

   logic rs1_r;
   logic rs2_r;
   logic srst_n;
   assign srst_n = rs2_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rs2_r <= rs1_r;
      end
   end

   av_req_s req;
   assign req = '{address, read, write, writedata, byteenable};

   // Bus: one wait cycle, answer in the next cycle
   logic ack_r;
   logic [7:0] flo_r;
   logic [7:0] fhi_r;
   logic [31:0] rd_nxt;
   logic hit_lo;
   logic hit_hi;
   logic hit_st;
   logic acc;
   logic wr_ok;
   logic [13:0] factor;
   logic over;

   assign acc = (req.read | req.write) & ~ack_r;
   assign hit_lo = (req.address == factor_low_addr);
   assign hit_hi = (req.address == factor_high_addr);
   assign hit_st = (req.address == divider_status_addr);
   assign wr_ok = ack_r & req.write & req.byteenable[0];
   assign factor = {fhi_r[5:0], flo_r};
   assign over = (factor > factor_max);

   logic run_r;
   assign rd_nxt = hit_lo ? {24'h0, flo_r} :
                   hit_hi ? {24'h0, 2'b00, fhi_r[5:0]} :
                   hit_st ? {30'h0, over, run_r} : 32'h0;

   // Handshake: waitrequest drops for exactly the answer cycle
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         ack_r <= 1'b0;
         waitrequest <= 1'b1;
      end else begin
         ack_r <= acc;
         waitrequest <= ~acc;
      end
   end

   // Read data is latched in the wait cycle and stands at the answer edge
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         readdata <= 32'h0;
      end else if (acc && req.read) begin
         readdata <= rd_nxt;
      end
   end

   // Writes land only at the edge where waitrequest is seen low
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         flo_r <= factor_low_rst;
      end else if (wr_ok && hit_lo) begin
         flo_r <= req.writedata[7:0];
      end
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         fhi_r <= factor_high_rst;
      end else if (wr_ok && hit_hi) begin
         fhi_r <= {2'b00, req.writedata[5:0]};
      end
   end

   // Reference is sampled on clk; 100 MHz is the edge-rate ceiling
   logic ref_d_r;
   logic ref_tick;
   logic div_tick;
   assign ref_tick = ref_clk_in & ~ref_d_r;

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         ref_d_r <= 1'b0;
      end else begin
         ref_d_r <= ref_clk_in;
      end
   end

   ref_divider #(.width(fw)) u_div (
      .clk(clk),
      .rst_n(srst_n),
      .ref_tick(ref_tick),
      .factor(factor),
      .div_tick(div_tick)
   );

   // Output toggles once per divided period; bypass follows the input
   logic tog_r;
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         tog_r <= 1'b0;
         run_r <= 1'b0;
         ref_out <= 1'b0;
      end else begin
         if (div_tick) begin
            tog_r <= ~tog_r;
            run_r <= 1'b1;
         end
         ref_out <= divide_en ? tog_r : ref_d_r;
      end
   end

   property p_reset_val;
      @(posedge clk) disable iff (!srst_n)
      $rose(srst_n) |-> (flo_r == 8'hff) && (fhi_r == 8'h3f);
   endproperty
   a_reset_val: assert property (p_reset_val)
      else $error("factor reset value wrong");

   property p_hi_top_zero;
      @(posedge clk) disable iff (!srst_n)
      fhi_r[7:6] == 2'b00;
   endproperty
   a_hi_top_zero: assert property (p_hi_top_zero)
      else $error("upper factor bits 7:6 not clear");

   sequence s_wr_lo;
      ack_r && write && byteenable[0] && address == factor_low_addr;
   endsequence
   property p_wr_lo;
      @(posedge clk) disable iff (!srst_n)
      s_wr_lo |=> flo_r == $past(writedata[7:0]);
   endproperty
   a_wr_lo: assert property (p_wr_lo)
      else $error("low factor byte not written");

   property p_wait_one;
      @(posedge clk) disable iff (!srst_n)
      (read || write) && !ack_r |=> !waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("bus answer late");

   property p_bypass;
      @(posedge clk) disable iff (!srst_n)
      factor == 14'h0 && ref_tick |=> div_tick;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("zero factor does not pass through");

   property p_over;
      @(posedge clk) disable iff (!srst_n)
      ack_r && read && address == divider_status_addr
         |-> readdata[stat_over_bit] == (factor > 14'h30d3);
   endproperty
   a_over: assert property (p_over)
      else $error("over-limit flag wrong");

   property p_rd_hi;
      @(posedge clk) disable iff (!srst_n)
      ack_r && read && address == factor_high_addr
         |-> readdata == {26'h0, fhi_r[5:0]};
   endproperty
   a_rd_hi: assert property (p_rd_hi)
      else $error("upper factor readback wrong");

   property p_tog;
      @(posedge clk) disable iff (!srst_n)
      div_tick |=> tog_r != $past(tog_r);
   endproperty
   a_tog: assert property (p_tog)
      else $error("divided output did not toggle");

   // A write with lane 0 disabled leaves both factor bytes alone
   sequence s_wr_masked;
      ack_r && write && !byteenable[0];
   endsequence
   property p_wr_masked;
      @(posedge clk) disable iff (!srst_n)
      s_wr_masked |=> $stable(flo_r) && $stable(fhi_r);
   endproperty
   a_wr_masked: assert property (p_wr_masked)
      else $error("masked write changed a factor byte");

   sequence s_wr_hi;
      ack_r && write && byteenable[0] && address == factor_high_addr;
   endsequence
   property p_wr_hi;
      @(posedge clk) disable iff (!srst_n)
      s_wr_hi |=> fhi_r == {2'b00, $past(writedata[5:0])};
   endproperty
   a_wr_hi: assert property (p_wr_hi)
      else $error("upper factor byte not written");

   property p_rd_lo;
      @(posedge clk) disable iff (!srst_n)
      ack_r && read && address == factor_low_addr
         |-> readdata == {24'h0, flo_r};
   endproperty
   a_rd_lo: assert property (p_rd_lo)
      else $error("lower factor readback wrong");

   property p_rd_run;
      @(posedge clk) disable iff (!srst_n)
      ack_r && read && address == divider_status_addr
         |-> readdata[stat_run_bit] == $past(run_r);
   endproperty
   a_rd_run: assert property (p_rd_run)
      else $error("running flag readback wrong");

   property p_rd_unmapped;
      @(posedge clk) disable iff (!srst_n)
      ack_r && read && !hit_lo && !hit_hi && !hit_st
         |-> readdata == 32'h0;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped read not zero");

   // The answer stands for a single cycle
   property p_wait_single;
      @(posedge clk) disable iff (!srst_n)
      !waitrequest |=> waitrequest;
   endproperty
   a_wait_single: assert property (p_wait_single)
      else $error("waitrequest low for more than one cycle");

   property p_idle_wait;
      @(posedge clk) disable iff (!srst_n)
      !read && !write |=> waitrequest;
   endproperty
   a_idle_wait: assert property (p_idle_wait)
      else $error("waitrequest low without a request");

   // Output path selection, one register stage behind its source
   property p_out_div;
      @(posedge clk) disable iff (!srst_n)
      divide_en |=> ref_out == $past(tog_r);
   endproperty
   a_out_div: assert property (p_out_div)
      else $error("divided output does not follow the toggle");

   property p_out_bypass;
      @(posedge clk) disable iff (!srst_n)
      !divide_en |=> ref_out == $past(ref_d_r);
   endproperty
   a_out_bypass: assert property (p_out_bypass)
      else $error("bypass output does not follow the reference");

   // One tick per rising reference edge, never two in a row
   sequence s_ref_rise;
      ref_clk_in && !ref_d_r;
   endsequence
   property p_one_tick;
      @(posedge clk) disable iff (!srst_n)
      s_ref_rise |=> !ref_tick;
   endproperty
   a_one_tick: assert property (p_one_tick)
      else $error("reference edge counted twice");

   // Running flag sets with the first divided tick
   property p_run;
      @(posedge clk) disable iff (!srst_n)
      div_tick |=> run_r;
   endproperty
   a_run: assert property (p_run)
      else $error("running flag not set");

endmodule : input_ref_prescaler

//--- bench/ref_source.sv
`timescale 1ns/1ps
module ref_source #(
   parameter int half = 2
) (
   // Clock
   input wire logic clk,
   // Gate and reference line
   input wire logic run,
   output logic ref_clk
);
   int cnt = 0;

   // Stands low while stopped; square wave of 2*half clk periods otherwise
   always @(posedge clk) begin
      if (!run) begin
         cnt <= 0;
         ref_clk <= 1'b0;
      end else if (cnt == half - 1) begin
         cnt <= 0;
         ref_clk <= ~ref_clk;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : ref_source

//--- bench/test_input_ref_prescaler.sv
`timescale 1ns/1ps
module test_input_ref_prescaler
   import prescaler_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = '0;
   logic [3:0] byteenable = 4'h1;
   logic [31:0] readdata;
   logic waitrequest;
   logic ref_clk_in;
   logic divide_en = 1'b1;
   logic ref_out;
   logic run = 1'b0;
   logic [31:0] q;
   logic h1;
   logic h2;
   int n_fail = 0;
   int num_checks = 0;
   int f;
   logic [13:0] facs [3] = '{14'h0, 14'h2, 14'h101};

   always #5 clk = ~clk;

   input_ref_prescaler #(.fw(factor_w)) DUT (.clk(clk), .rst_n(rst_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .ref_clk_in(ref_clk_in),
      .divide_en(divide_en), .ref_out(ref_out));

   ref_source #(.half(2)) src (.clk(clk), .run(run), .ref_clk(ref_clk_in));

   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0)
         chk("waitrequest", 32'h0, 32'h1);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   // Counts reference rising edges until ref_out next changes
   task wait_toggle(output int edges);
      logic pr;
      logic po;
      int n;
      edges = 0;
      n = 0;
      pr = ref_clk_in;
      po = ref_out;
      while (ref_out === po && n < 5000) begin
         @(posedge clk);
         n++;
         if (ref_clk_in === 1'b1 && pr === 1'b0)
            edges++;
         pr = ref_clk_in;
      end
      if (n >= 5000)
         chk("toggle wait", 32'h0, 32'h1);
   endtask : wait_toggle

   task do_reset;
      run <= 1'b0;
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset

   initial begin
      #300000;
      n_fail++;
      report_and_stop;
   end

   initial begin
      do_reset;
      bus(1'b0, factor_low_addr, 8'h0);
      chk("low reset", {24'h0, factor_low_rst}, q);
      bus(1'b0, factor_high_addr, 8'h0);
      chk("high reset", {24'h0, factor_high_rst}, q);
      // Reset factor 3fff lies above the limit: over set, not running
      bus(1'b0, divider_status_addr, 8'h0);
      chk("status reset", 32'h2, q);
      bus(1'b1, factor_high_addr, 8'hff);
      bus(1'b0, factor_high_addr, 8'h0);
      chk("high unused bits", 32'h3f, q);
      byteenable <= 4'h0;
      bus(1'b1, factor_low_addr, 8'h12);
      byteenable <= 4'h1;
      bus(1'b0, factor_low_addr, 8'h0);
      chk("masked write", {24'h0, factor_low_rst}, q);
      bus(1'b1, factor_high_addr, {2'b00, factor_max[13:8]});
      bus(1'b1, factor_low_addr, factor_max[7:0]);
      bus(1'b0, factor_low_addr, 8'h0);
      chk("low readback", {24'h0, factor_max[7:0]}, q);
      bus(1'b0, divider_status_addr, 8'h0);
      chk("status at limit", 32'h0, q);
      bus(1'b1, 10'h3f0, 8'h55);
      bus(1'b0, 10'h3f0, 8'h0);
      chk("unmapped", 32'h0, q);
      $display("register test done");
      // Reference held still while the counter restarts from reset
      foreach (facs[i]) begin
         do_reset;
         bus(1'b1, factor_high_addr, {2'b00, facs[i][13:8]});
         bus(1'b1, factor_low_addr, facs[i][7:0]);
         bus(1'b0, factor_high_addr, 8'h0);
         chk("high readback", {26'h0, facs[i][13:8]}, q);
         run <= 1'b1;
         wait_toggle(f);
         wait_toggle(f);
         chk("edges per toggle", {18'h0, facs[i]} + 32'h1, f);
         wait_toggle(f);
         chk("edges per toggle", {18'h0, facs[i]} + 32'h1, f);
         bus(1'b0, divider_status_addr, 8'h0);
         chk("status running", 32'h1, q);
         $display("divide test %0d done", i);
      end
      // Bypass: output is the reference two clocks late
      divide_en <= 1'b0;
      @(posedge clk);
      h1 = ref_clk_in;
      @(posedge clk);
      h2 = h1;
      h1 = ref_clk_in;
      repeat (16) begin
         @(posedge clk);
         chk("bypass", {31'h0, h2}, {31'h0, ref_out});
         h2 = h1;
         h1 = ref_clk_in;
      end
      $display("bypass test done");
      report_and_stop;
   end
endmodule : test_input_ref_prescaler
